// ===== rtl/isl_pkg.sv
// Shared types and constants for the I2C slave engine
package isl_pkg;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_HOLD   = 3'b010,
    ST_ACK    = 3'b011,
    ST_UPD    = 3'b100,
    ST_TXWAIT = 3'b101,
    ST_TX     = 3'b110,
    ST_TXACK  = 3'b111
  } isl_state_t;

  // Which byte of the frame is being received
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_LO   = 2'b01,
    PH_DATA = 2'b10
  } isl_phase_t;

  // Upper five bits of a 10-bit high address byte
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  // Bits per byte on the wire
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic REL_RST = 1'b1;
  // Position of A9 and A8 inside the slave address register
  localparam int A9_POS = 2;
  localparam int A8_POS = 1;

endpackage : isl_pkg

// ===== rtl/isl_bus_if.sv
// Sampled bus levels and bus events between sampler and engine
`timescale 1ns/1ps
`default_nettype none
interface isl_bus_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop);
  modport eng (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : isl_bus_if
`default_nettype wire

// ===== rtl/isl_pin_sampler.sv
// Synchroniser and edge/condition detector for SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module isl_pin_sampler
  import isl_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Raw bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  // Events towards the engine
  isl_bus_if.src bus
);

  ////////////////////////////////////////////////////////////////////////
  // State: {scl, sda} through two sync stages plus a history stage
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } isl_samp_t;

  isl_samp_t r_reg;
  isl_samp_t r_next;

  // Idle bus reads high, so reset to high to avoid false events
  always_comb
  begin
    r_next = r_reg;
    r_next.s1 = {i_scl, i_sda};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
  end

  // Frozen while the enable is low
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      r_reg <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
    else if (i_clk_en)
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Only the second stage and its history are looked at
  assign bus.scl = r_reg.s2[1];
  assign bus.sda = r_reg.s2[0];
  assign bus.scl_rise = r_reg.s2[1] & ~r_reg.s3[1];
  assign bus.scl_fall = ~r_reg.s2[1] & r_reg.s3[1];
  // SDA moves while SCL stays high
  assign bus.start = r_reg.s2[1] & r_reg.s3[1] & ~r_reg.s2[0] & r_reg.s3[0];
  assign bus.stop = r_reg.s2[1] & r_reg.s3[1] & r_reg.s2[0] & ~r_reg.s3[0];

endmodule : isl_pin_sampler
`default_nettype wire

// ===== rtl/isl_slave.sv
// I2C slave engine: address match, receive, transmit, stretching
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - First byte after start compared; mismatch idles silently
// - 7-bit match ignores received LSB
// - 10-bit high byte is 11110 A9 A8 0
// - Matched write high byte sets update flag, stretches
// - Low byte always flags and stretches, even mismatched
// - Address write clears update flag, releases clock
// - 10-bit read needs prior full write match
// - Write address clears rw flag, buffers, acks
// - Nack when overflow set, or buffer full without override
// - Transfer flag set per byte, software clears
// - Stretch enable holds clock after received bytes
// - Buffer read clears buffer full flag
// - Start/stop status flags, optional flag interrupts
// - Hold modes flag and stretch after eighth fall
// - Hold modes send software chosen ack value
// - Hold modes flag after ninth fall only on ack or after a low address byte
// - Read address sets rw flag, buffers, acks
// - After read ack stretch until release; buffer write loads transmitter
// - Transmit MSB first, bits change on falling edge
// - Master ack latched on ninth rise; nack ends
// - Transmit flag set on ninth falling edge
// - Driven high read low sets collision, idles
// - Without hold modes hardware acks automatically
// - Ack time flag after eighth fall in hold modes
module isl_slave
  import isl_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Bus pins, open drain
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Configuration
  input wire logic i_ten_bit_mode,
  input wire logic i_stretch_enable,
  input wire logic i_address_hold_enable,
  input wire logic i_data_hold_enable,
  input wire logic i_buffer_override_enable,
  input wire logic i_slave_collision_detect_enable,
  input wire logic i_start_irq_enable,
  input wire logic i_stop_irq_enable,
  input wire logic i_ack_value_select,
  // Software strobes
  input wire logic i_addr_wr,
  input wire logic [7:0] i_addr_wdata,
  input wire logic i_buf_wr,
  input wire logic [7:0] i_buf_wdata,
  input wire logic i_buf_rd,
  input wire logic i_clock_release_set,
  input wire logic i_irq_clear,
  input wire logic i_collision_clear,
  input wire logic i_overflow_clear,
  // Status
  output logic [7:0] o_slave_address_reg,
  output logic [7:0] o_data_buffer,
  output logic o_transfer_irq_flag,
  output logic o_collision_irq_flag,
  output logic o_buffer_full_flag,
  output logic o_receive_overflow_flag,
  output logic o_addr_update_flag,
  output logic o_clock_release_bit,
  output logic o_ack_time_flag,
  output logic o_master_ack_result,
  output logic o_rw_flag,
  output logic o_data_not_addr_flag,
  output logic o_start_flag,
  output logic o_stop_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Whole engine state
  typedef struct packed {
    isl_state_t st;     // Engine state
    isl_phase_t ph;     // Byte kind being received
    logic [3:0] cnt;    // Rising edges seen in this byte
    logic [7:0] sr;     // Receive shift register
    logic [7:0] tx;     // Transmit shift register
    logic [7:0] addr;   // Slave address register
    logic [7:0] dbuf;   // Data buffer
    logic irq;          // Transfer interrupt flag
    logic bcl;          // Collision interrupt flag
    logic full;         // Buffer full
    logic ov;           // Receive overflow
    logic upd;          // Address update needed
    logic rel;          // Clock release bit
    logic atim;         // Ack time flag
    logic mack;         // Master ack result
    logic rw;           // Read/write of last address
    logic da;           // Last byte was data
    logic sflag;        // Start seen
    logic pflag;        // Stop seen
    logic m10;          // Full 10-bit write match seen
    logic lo_ok;        // Low address byte matched
    logic ack;          // Ack to send in slot nine
    logic scl_oe;       // Holding SCL low
    logic sda_oe;       // Pulling SDA low
  } isl_core_t;

  isl_core_t r_reg;
  isl_core_t r_next;

  // Sampled bus events
  isl_bus_if bus ();

  ////////////////////////////////////////////////////////////////////////
  // Address decode helpers
  function automatic logic match7(input logic [7:0] rx,
                                  input logic [7:0] adr);
    match7 = (rx[7:1] == adr[7:1]);
  endfunction : match7

  function automatic logic match10hi(input logic [7:0] rx,
                                     input logic [7:0] adr);
    match10hi = (rx[7:1] == {TEN_BIT_HDR, adr[A9_POS], adr[A8_POS]});
  endfunction : match10hi

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and condition detector
  isl_pin_sampler u_samp (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .bus       (bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic hit;
  logic over;
  logic hold;
  logic hold_mode;
  logic stretch;

  // Whole next-state decision in one process, so every read is sensed
  always_comb
  begin
    r_next = r_reg;
    hit = 1'b0;
    over = r_reg.ov | (r_reg.full & ~i_buffer_override_enable);
    hold = 1'b0;
    hold_mode = i_address_hold_enable | i_data_hold_enable;
    stretch = 1'b0;
    // Software clears first so a same-cycle hardware set wins
    if (i_irq_clear)
      r_next.irq = 1'b0;
    if (i_collision_clear)
      r_next.bcl = 1'b0;
    if (i_overflow_clear)
      r_next.ov = 1'b0;
    if (i_buf_rd)
      r_next.full = 1'b0;
    if (i_clock_release_set)
      r_next.rel = 1'b1;
    // Address write also ends an update stretch
    if (i_addr_wr)
    begin
      r_next.addr = i_addr_wdata;
      r_next.upd = 1'b0;
    end
    // Buffer write also feeds the transmitter while it waits
    if (i_buf_wr)
    begin
      r_next.dbuf = i_buf_wdata;
      r_next.full = 1'b1;
      if (r_reg.st == ST_TXWAIT)
        r_next.tx = i_buf_wdata;
    end

    unique case (r_reg.st)
      ST_IDLE:
      begin
        r_next.ack = 1'b0;
      end
      // Shift in a byte, judge it after the eighth fall
      ST_RX:
      begin
        if (bus.scl_rise)
        begin
          r_next.sr = {r_reg.sr[6:0], bus.sda};
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        if (bus.scl_fall && r_reg.cnt == BITS_PER_BYTE)
        begin
          r_next.cnt = 4'h0;
          unique case (r_reg.ph)
            PH_ADDR:
            begin
              if (i_ten_bit_mode)
              begin
                // Read only after a complete write match
                hit = match10hi(r_reg.sr, r_reg.addr) &
                      (~r_reg.sr[0] | r_reg.m10);
                if (~match10hi(r_reg.sr, r_reg.addr) | ~r_reg.sr[0])
                  r_next.m10 = 1'b0;
              end
              else
                hit = match7(r_reg.sr, r_reg.addr);
            end
            PH_LO:
            begin
              hit = (r_reg.sr == r_reg.addr);
              r_next.lo_ok = hit;
            end
            default:
            begin
              hit = 1'b1;
            end
          endcase
          if (hit || r_reg.ph == PH_LO)
          begin
            // Overrun keeps old data and marks overflow
            if (hit && r_reg.full && !i_buffer_override_enable)
              r_next.ov = 1'b1;
            if (hit && !over)
            begin
              r_next.dbuf = r_reg.sr;
              r_next.full = 1'b1;
            end
            if (r_reg.ph == PH_ADDR)
            begin
              r_next.rw = r_reg.sr[0];
              r_next.da = 1'b0;
            end
            else if (r_reg.ph == PH_DATA)
              r_next.da = 1'b1;
            r_next.ack = hit & ~over;
            hold = hit & ((r_reg.ph == PH_DATA) ?
                   i_data_hold_enable : i_address_hold_enable);
            if (hold_mode)
              r_next.atim = 1'b1;
            if (hold)
            begin
              r_next.irq = 1'b1;
              r_next.rel = 1'b0;
              r_next.st = ST_HOLD;
            end
            else
              r_next.st = ST_ACK;
          end
          else
            r_next.st = ST_IDLE;
        end
      end
      // Software inspects the byte, picks the ack value
      ST_HOLD:
      begin
        if (r_next.rel)
        begin
          r_next.ack = ~i_ack_value_select;
          r_next.st = ST_ACK;
        end
      end
      // Ack slot, then decide how the frame goes on
      ST_ACK:
      begin
        if (bus.scl_fall)
        begin
          r_next.atim = 1'b0;
          if (!hold_mode || r_reg.ack || r_reg.ph == PH_LO)
            r_next.irq = 1'b1;
          if (r_reg.ph == PH_LO)
          begin
            r_next.upd = 1'b1;
            r_next.st = ST_UPD;
          end
          else if (!r_reg.ack)
            r_next.st = ST_IDLE;
          else if (r_reg.ph == PH_ADDR && i_ten_bit_mode && !r_reg.rw)
          begin
            r_next.upd = 1'b1;
            r_next.st = ST_UPD;
          end
          else if (r_reg.ph == PH_ADDR && r_reg.rw)
          begin
            r_next.rel = 1'b0;
            r_next.st = ST_TXWAIT;
          end
          else
          begin
            r_next.st = ST_RX;
            r_next.ph = PH_DATA;
            if (i_stretch_enable)
              r_next.rel = 1'b0;
          end
        end
      end
      // Stretch until software rewrites the address
      ST_UPD:
      begin
        if (i_addr_wr)
        begin
          r_next.cnt = 4'h0;
          if (r_reg.ph == PH_ADDR)
          begin
            r_next.st = ST_RX;
            r_next.ph = PH_LO;
          end
          else if (r_reg.lo_ok)
          begin
            r_next.st = ST_RX;
            r_next.ph = PH_DATA;
            r_next.m10 = 1'b1;
          end
          else
            r_next.st = ST_IDLE;
        end
      end
      // Wait for the clock release; a buffer write meanwhile loads the transmitter
      ST_TXWAIT:
      begin
        if (r_next.rel)
        begin
          r_next.st = ST_TX;
          r_next.cnt = 4'h0;
        end
      end
      // Shift out; check the line while driving high
      ST_TX:
      begin
        if (bus.scl_rise)
        begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.tx[7] && !bus.sda && i_slave_collision_detect_enable)
          begin
            r_next.bcl = 1'b1;
            r_next.st = ST_IDLE;
          end
        end
        if (bus.scl_fall)
        begin
          if (r_reg.cnt == BITS_PER_BYTE)
          begin
            r_next.st = ST_TXACK;
            r_next.full = 1'b0;
          end
          else
            r_next.tx = {r_reg.tx[6:0], 1'b0};
        end
      end
      // Master ack slot
      ST_TXACK:
      begin
        if (bus.scl_rise)
          r_next.mack = bus.sda;
        if (bus.scl_fall)
        begin
          r_next.irq = 1'b1;
          if (r_reg.mack)
            r_next.st = ST_IDLE;
          else
          begin
            r_next.rel = 1'b0;
            r_next.st = ST_TXWAIT;
          end
        end
      end
    endcase

    // Start or restart resets the byte engine
    if (bus.start)
    begin
      r_next.st = ST_RX;
      r_next.ph = PH_ADDR;
      r_next.cnt = 4'h0;
      r_next.rel = 1'b1;
      r_next.atim = 1'b0;
      r_next.sflag = 1'b1;
      r_next.pflag = 1'b0;
      if (i_start_irq_enable)
        r_next.irq = 1'b1;
    end
    // Stop ends the session and the prior match
    if (bus.stop)
    begin
      r_next.st = ST_IDLE;
      r_next.rel = 1'b1;
      r_next.m10 = 1'b0;
      r_next.atim = 1'b0;
      r_next.pflag = 1'b1;
      r_next.sflag = 1'b0;
      if (i_stop_irq_enable)
        r_next.irq = 1'b1;
    end

    // Hold SCL only once it is already low, so no high time is cut
    stretch = (r_next.st == ST_UPD) |
              (~r_next.rel & r_next.st != ST_IDLE);
    r_next.scl_oe = stretch & (r_reg.scl_oe | ~bus.scl);
    // Data line drive
    if (r_next.st == ST_ACK)
      r_next.sda_oe = r_next.ack;
    else if (r_next.st == ST_TX)
      r_next.sda_oe = ~r_next.tx[7];
    else
      r_next.sda_oe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, frozen while the enable is low
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.ph <= PH_ADDR;
      r_reg.addr <= ADDR_RST;
      r_reg.dbuf <= BUF_RST;
      r_reg.rel <= REL_RST;
    end
    else if (i_clk_en)
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs from the state register; pin out levels tied low
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe = r_reg.scl_oe;
  assign o_sda_oe = r_reg.sda_oe;
  assign o_slave_address_reg = r_reg.addr;
  assign o_data_buffer = r_reg.dbuf;
  assign o_transfer_irq_flag = r_reg.irq;
  assign o_collision_irq_flag = r_reg.bcl;
  assign o_buffer_full_flag = r_reg.full;
  assign o_receive_overflow_flag = r_reg.ov;
  assign o_addr_update_flag = r_reg.upd;
  assign o_clock_release_bit = r_reg.rel;
  assign o_ack_time_flag = r_reg.atim;
  assign o_master_ack_result = r_reg.mack;
  assign o_rw_flag = r_reg.rw;
  assign o_data_not_addr_flag = r_reg.da;
  assign o_start_flag = r_reg.sflag;
  assign o_stop_flag = r_reg.pflag;

endmodule : isl_slave
`default_nettype wire

// ===== verification/isl_checker.sv
// Port-level assertions for the I2C slave engine
`timescale 1ns/1ps
`default_nettype none
module isl_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Watched inputs
  input wire logic i_scl,
  input wire logic i_slave_collision_detect_enable,
  input wire logic i_address_hold_enable,
  input wire logic i_data_hold_enable,
  input wire logic i_addr_wr,
  input wire logic [7:0] i_addr_wdata,
  input wire logic i_buf_rd,
  input wire logic i_clock_release_set,
  input wire logic i_irq_clear,
  input wire logic i_collision_clear,
  // Watched outputs
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic [7:0] o_slave_address_reg,
  input wire logic o_transfer_irq_flag,
  input wire logic o_collision_irq_flag,
  input wire logic o_buffer_full_flag,
  input wire logic o_addr_update_flag,
  input wire logic o_clock_release_bit,
  input wire logic o_ack_time_flag
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Update flag standing; slack of two cycles for the clock hold to land
  sequence s_upd_held;
    o_addr_update_flag [*3];
  endsequence
  // Address write while waiting on the update flag
  sequence s_upd_write;
    o_addr_update_flag && i_addr_wr && o_clock_release_bit;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_addr_load: assert property (i_addr_wr |=>
    o_slave_address_reg == $past(i_addr_wdata)) else $error("addr load");
  a_upd_release: assert property (s_upd_write |=>
    !o_addr_update_flag ##[0:3] !o_scl_oe) else $error("upd release");
  a_upd_holds: assert property (s_upd_held |-> o_scl_oe)
    else $error("upd hold");
  a_rel_set: assert property (i_clock_release_set &&
    !o_addr_update_flag |=> o_clock_release_bit) else $error("rel set");
  a_full_read: assert property (i_buf_rd && o_scl_oe |=>
    !o_buffer_full_flag) else $error("full clear");
  a_irq_sticky: assert property (o_transfer_irq_flag &&
    !i_irq_clear |=> o_transfer_irq_flag) else $error("irq lost");
  a_irq_clear: assert property (i_irq_clear && o_scl_oe |=>
    !o_transfer_irq_flag) else $error("irq clear");
  a_coll_sticky: assert property (o_collision_irq_flag &&
    !i_collision_clear |=> o_collision_irq_flag) else $error("coll lost");
  a_coll_gate: assert property (!i_slave_collision_detect_enable &&
    !o_collision_irq_flag |=> !o_collision_irq_flag) else $error("coll");
  a_atim_gate: assert property (!i_address_hold_enable &&
    !i_data_hold_enable |=> !$rose(o_ack_time_flag)) else $error("atim");
  // Data line only moves while the clock is low, unless collision detect is enabled
  a_sda_stable: assert property (i_scl && $past(i_scl) &&
    !i_slave_collision_detect_enable |-> $stable(o_sda_oe))
    else $error("sda moved");
endmodule : isl_checker
bind isl_slave isl_checker u_chk (.i_sys_clk, .i_rst, .i_scl,
  .i_slave_collision_detect_enable, .i_address_hold_enable,
  .i_data_hold_enable, .i_addr_wr, .i_addr_wdata, .i_buf_rd,
  .i_clock_release_set, .i_irq_clear, .i_collision_clear, .o_scl_oe,
  .o_sda_oe, .o_slave_address_reg, .o_transfer_irq_flag,
  .o_collision_irq_flag, .o_buffer_full_flag, .o_addr_update_flag,
  .o_clock_release_bit, .o_ack_time_flag);
`default_nettype wire

// ===== verification/isl_master_model.sv
// Behavioural I2C bus master on open-drain SCL and SDA
`timescale 1ns/1ps
`default_nettype none
module isl_master_model (
  // Wired bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull-down requests, high pulls the line low
  output logic o_scl_low,
  output logic o_sda_low
);
  // Released bus idles high through the pull-ups
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One pulse, 300 ns low, 100 ns high; waits out slave stretching
  task automatic bit_io(input logic b, output logic s);
    #150 o_sda_low = !b;
    #150 o_scl_low = 1'b0;
    wait (i_scl === 1'b1);
    #50 s = i_sda;
    #50 o_scl_low = 1'b1;
  endtask : bit_io
  // Start, or restart when the clock is parked low
  task automatic start;
    if (o_scl_low)
    begin
      #150 o_sda_low = 1'b0;
      #150 o_scl_low = 1'b0;
      wait (i_scl === 1'b1);
    end
    #100 o_sda_low = 1'b1;
    #100 o_scl_low = 1'b1;
  endtask : start
  // Stop, then bus idle
  task automatic stop;
    #150 o_sda_low = 1'b1;
    #150 o_scl_low = 1'b0;
    wait (i_scl === 1'b1);
    #100 o_sda_low = 1'b0;
    #400;
  endtask : stop
  // Byte out, MSB first, then slave acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wr
  // Byte in; jam pulls SDA low on all eight data bits to force a collision
  task automatic rd(input logic nak, input logic jam, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(!jam, d[i]);
    bit_io(nak, s);
  endtask : rd
endmodule : isl_master_model
`default_nettype wire

// ===== verification/test_isl_slave.sv
// Self-checking bench for the I2C slave engine
`timescale 1ns/1ps
`default_nettype none
module test_isl_slave;
  // Clock, reset, config bits and one-hot software strobes
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] cfg = 9'h000;
  logic [6:0] stb = 7'h00;
  logic [7:0] wd = 8'h00;
  // Observed outputs
  logic scl_oe, sda_oe, m_scl, m_sda, ack;
  logic irq, coll, full, ovf, upd, rel, atim, mack, rw, sf, pf, da;
  logic [7:0] buffer, rdat;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  // Open-drain wires with pull-ups
  wire logic scl = !(scl_oe || m_scl);
  wire logic sda = !(sda_oe || m_sda);
  always #25 clk = !clk;
  isl_slave u_dut (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_scl(scl), .o_scl_out(), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_ten_bit_mode(cfg[0]), .i_stretch_enable(cfg[1]),
    .i_address_hold_enable(cfg[2]), .i_data_hold_enable(cfg[3]),
    .i_buffer_override_enable(cfg[4]),
    .i_slave_collision_detect_enable(cfg[5]),
    .i_start_irq_enable(cfg[6]), .i_stop_irq_enable(cfg[7]),
    .i_ack_value_select(cfg[8]), .i_addr_wr(stb[0]), .i_addr_wdata(wd),
    .i_buf_wr(stb[1]), .i_buf_wdata(wd), .i_buf_rd(stb[2]),
    .i_clock_release_set(stb[3]), .i_irq_clear(stb[4]),
    .i_collision_clear(stb[5]), .i_overflow_clear(stb[6]),
    .o_slave_address_reg(), .o_data_buffer(buffer),
    .o_transfer_irq_flag(irq), .o_collision_irq_flag(coll),
    .o_buffer_full_flag(full), .o_receive_overflow_flag(ovf),
    .o_addr_update_flag(upd), .o_clock_release_bit(rel),
    .o_ack_time_flag(atim), .o_master_ack_result(mack), .o_rw_flag(rw),
    .o_data_not_addr_flag(da), .o_start_flag(sf), .o_stop_flag(pf));
  isl_master_model u_mst (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl),
    .o_sda_low(m_sda));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle strobe k: 0 addr, 1 buf wr, 2 buf rd, 3 release, 4-6 clears
  task automatic sw(input int k, input logic [7:0] d);
    @(posedge clk);
    stb <= 7'(1 << k);
    wd <= d;
    @(posedge clk);
    stb <= 7'h00;
    @(posedge clk);
  endtask : sw
  // Let the roughly three-clock pin latency settle
  task automatic wt;
    repeat (8) @(posedge clk);
  endtask : wt
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // Hang guard; the whole run needs well under a third of this
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wt();
    chk(8'({rel, scl_oe, sda_oe, full, irq}), 8'h10);
    chk(buffer, 8'h00);
    // 7-bit write, auto ack, stretch, overflow
    sw(0, 8'h52);
    cfg <= 9'h040;
    u_mst.start();
    wt();
    chk(8'({sf, irq}), 8'h03);
    sw(4, 8'h00);
    u_mst.wr(8'h52, ack);
    wt();
    chk(8'({ack, full, rw, irq, da}), 8'h0a);
    chk(buffer, 8'h52);
    sw(2, 8'h00);
    chk(8'(full), 8'h00);
    sw(4, 8'h00);
    u_mst.wr(8'ha5, ack);
    wt();
    chk({ack, irq, buffer[5:0]}, 8'h65);
    sw(2, 8'h00);
    cfg <= 9'h002;
    u_mst.wr(8'h77, ack);
    wt();
    chk(8'({da, ack, rel, scl_oe}), 8'h09);
    sw(3, 8'h00);
    chk(8'(scl_oe), 8'h00);
    cfg <= 9'h000;
    u_mst.wr(8'h3c, ack);
    wt();
    chk(8'({ack, ovf}), 8'h03);
    u_mst.stop();
    wt();
    chk(8'({sf, pf}), 8'h01);
    $display("write test done");
    // Address mismatch stays silent
    sw(2, 8'h00);
    sw(6, 8'h00);
    sw(4, 8'h00);
    u_mst.start();
    u_mst.wr(8'h60, ack);
    wt();
    chk(8'({ack, irq, full}), 8'h04);
    cfg <= 9'h080;
    u_mst.stop();
    chk(8'(irq), 8'h01);
    $display("mismatch test done");
    // 7-bit read, ack then nack
    u_mst.start();
    u_mst.wr(8'h53, ack);
    wt();
    chk(8'({ack, rw, rel, scl_oe}), 8'h05);
    chk(buffer, 8'h53);
    sw(2, 8'h00);
    sw(4, 8'h00);
    sw(1, 8'hc6);
    sw(3, 8'h00);
    u_mst.rd(1'b0, 1'b0, rdat);
    wt();
    chk(rdat, 8'hc6);
    chk(8'({mack, irq, rel, scl_oe}), 8'h05);
    sw(4, 8'h00);
    sw(1, 8'h3b);
    sw(3, 8'h00);
    u_mst.rd(1'b1, 1'b0, rdat);
    wt();
    chk(rdat, 8'h3b);
    chk(8'({mack, irq, scl_oe}), 8'h06);
    u_mst.stop();
    $display("read test done");
    // Collision while transmitting
    cfg <= 9'h020;
    u_mst.start();
    u_mst.wr(8'h53, ack);
    wt();
    sw(1, 8'hf0);
    sw(3, 8'h00);
    u_mst.rd(1'b1, 1'b1, rdat);
    wt();
    chk(8'({coll, scl_oe}), 8'h02);
    sw(5, 8'h00);
    u_mst.stop();
    $display("collision test done");
    // 10-bit: high, low, restart read, then low mismatch
    cfg <= 9'h001;
    sw(0, 8'h06);
    sw(2, 8'h00);
    u_mst.start();
    u_mst.wr(8'hf6, ack);
    wt();
    chk(8'({ack, upd, scl_oe}), 8'h03);
    sw(2, 8'h00);
    sw(0, 8'h9c);
    chk(8'({upd, scl_oe}), 8'h00);
    u_mst.wr(8'h9c, ack);
    wt();
    chk(8'({ack, upd, irq}), 8'h03);
    sw(0, 8'h06);
    sw(2, 8'h00);
    u_mst.start();
    u_mst.wr(8'hf7, ack);
    wt();
    chk(8'({ack, rw}), 8'h01);
    sw(1, 8'h55);
    sw(3, 8'h00);
    u_mst.rd(1'b1, 1'b0, rdat);
    chk(rdat, 8'h55);
    sw(2, 8'h00);
    sw(4, 8'h00);
    u_mst.start();
    u_mst.wr(8'hf6, ack);
    wt();
    sw(2, 8'h00);
    sw(0, 8'h9c);
    u_mst.wr(8'h9d, ack);
    wt();
    chk(8'({ack, upd, scl_oe, full}), 8'h0e);
    sw(0, 8'h06);
    u_mst.stop();
    $display("ten-bit test done");
    // Hold modes: software chooses a nack
    cfg <= 9'h00c;
    sw(0, 8'h52);
    sw(4, 8'h00);
    u_mst.start();
    fork
      u_mst.wr(8'h52, ack);
      begin
        for (int n = 0; n < 400 && rel; n++)
          @(posedge clk);
        chk(8'({irq, atim, scl_oe}), 8'h07);
        cfg <= 9'h10c;
        sw(4, 8'h00);
        sw(3, 8'h00);
      end
    join
    wt();
    chk(8'({ack, irq}), 8'h02);
    u_mst.stop();
    $display("hold test done");
    report_and_stop();
  end
endmodule : test_isl_slave
`default_nettype wire
